// ### shared/lhs_pkg.sv
// Constants and types shared by the home-search sequencer blocks
package lhs_pkg;
  // ============
  // Timing
  localparam int unsigned LHS_CLK_HZ       = 50_000_000;
  localparam int unsigned LHS_CLK_MHZ      = LHS_CLK_HZ / 1_000_000;
  localparam int unsigned LHS_ACC_TICK_US  = 1000;
  localparam int unsigned LHS_ACC_TICK_CYC = LHS_CLK_MHZ * LHS_ACC_TICK_US;
  localparam int unsigned LHS_DCC_WIDTH_US = 10;
  localparam int unsigned LHS_DCC_CYC      = LHS_CLK_MHZ * LHS_DCC_WIDTH_US;
  // ============
  // Widths
  localparam int LHS_SPD_W  = 16;
  localparam int LHS_MULT_W = 8;
  localparam int LHS_PPS_W  = 32;
  localparam int LHS_CNT_W  = 24;
  localparam int LHS_POS_W  = 32;
  localparam int LHS_SLOTS  = 64;
  localparam int LHS_SLOT_W = 6;
  localparam int LHS_PROG_W = 32;
  localparam int LHS_STEPS  = 4;
  localparam int LHS_TICK_W = 20;
  // ============
  // Step numbers and synchronised input positions
  localparam logic [1:0] LHS_STEP_FAST   = 2'h0;
  localparam logic [1:0] LHS_STEP_HOME   = 2'h1;
  localparam logic [1:0] LHS_STEP_INDEX  = 2'h2;
  localparam logic [1:0] LHS_STEP_OFFSET = 2'h3;
  localparam int LHS_IN_LMT_MINUS = 0;
  localparam int LHS_IN_LMT_PLUS  = 1;
  localparam int LHS_IN_NEAR      = 2;
  localparam int LHS_IN_HOME      = 3;
  localparam int LHS_IN_INDEX     = 4;
  localparam int LHS_IN_N         = 5;
  // ============
  // Sequencer states
  typedef enum logic [7:0] {
    LHS_IDLE  = 8'h01,
    LHS_PICK  = 8'h02,
    LHS_MOVE  = 8'h04,
    LHS_WSTOP = 8'h08,
    LHS_ESC   = 8'h10,
    LHS_ESCW  = 8'h20,
    LHS_CLEAR = 8'h40,
    LHS_FIN   = 8'h80
  } lhs_state_t;
endpackage : lhs_pkg

// ### shared/lhs_drv_if.sv
// Command link between the sequencer and the pulse generator
`timescale 1ns/1ns
`default_nettype none
interface lhs_drv_if;
  import lhs_pkg::*;
  logic                 go;
  logic                 ramp;
  logic                 count_en;
  logic                 stop_slow;
  logic                 stop_now;
  logic                 busy;
  logic                 pulse;
  logic [LHS_PPS_W-1:0] target_pps;
  logic [LHS_PPS_W-1:0] start_pps;
  logic [LHS_PPS_W-1:0] accel_pps;
  logic [LHS_CNT_W-1:0] count;
  modport seq (output go, ramp, count_en, stop_slow, stop_now, target_pps,
               start_pps, accel_pps, count, input busy, pulse);
  modport gen (input go, ramp, count_en, stop_slow, stop_now, target_pps,
               start_pps, accel_pps, count, output busy, pulse);
endinterface : lhs_drv_if
`default_nettype wire

// ### rtl/lhs_pulse_gen.sv
// Trapezoidal step pulse generator
`timescale 1ns/1ns
`default_nettype none
module lhs_pulse_gen #(
  parameter int unsigned ACC_TICK_CYC = lhs_pkg::LHS_ACC_TICK_CYC
) (
  input  wire logic mclk,
  input  wire logic reset,
  lhs_drv_if.gen    drv
);
  import lhs_pkg::*;

  localparam logic [LHS_PPS_W-1:0]  CLK_PPS  = LHS_PPS_W'(LHS_CLK_HZ);
  localparam logic [LHS_TICK_W-1:0] TICK_TOP = LHS_TICK_W'(ACC_TICK_CYC - 1);

  logic [LHS_PPS_W-1:0]  speed_q;
  logic [LHS_PPS_W-1:0]  phase_q;
  logic [LHS_CNT_W-1:0]  remain_q;
  logic [LHS_CNT_W-1:0]  ramp_cnt_q;
  logic [LHS_TICK_W-1:0] tick_q;
  logic                  busy_q;
  logic                  dec_q;
  logic                  ramp_q;
  logic                  pulse_q;

  // ============
  // Rate decode
  wire [LHS_PPS_W:0] phase_sum = {1'b0, phase_q} + {1'b0, speed_q};
  wire fire      = busy_q && (phase_sum >= {1'b0, CLK_PPS});
  wire tick      = busy_q && (tick_q == TICK_TOP);
  wire accel_ok  = !dec_q && (speed_q < drv.target_pps);
  wire near_end  = drv.count_en && (remain_q <= ramp_cnt_q);
  wire count_end = drv.count_en && (remain_q == '0);
  wire floor_hit = speed_q <= (drv.start_pps + drv.accel_pps);
  wire [LHS_PPS_W-1:0] speed_up = drv.target_pps - speed_q > drv.accel_pps
                                  ? speed_q + drv.accel_pps : drv.target_pps;

  assign drv.busy  = busy_q;
  assign drv.pulse = pulse_q;

  // ============
  // Motion
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      speed_q    <= '0;
      phase_q    <= '0;
      remain_q   <= '0;
      ramp_cnt_q <= '0;
      tick_q     <= '0;
      busy_q     <= 1'b0;
      dec_q      <= 1'b0;
      ramp_q     <= 1'b0;
      pulse_q    <= 1'b0;
    end else if (!busy_q) begin
      pulse_q <= 1'b0;
      if (drv.go) begin
        busy_q     <= 1'b1;
        ramp_q     <= drv.ramp;
        speed_q    <= drv.ramp ? drv.start_pps : drv.target_pps;
        phase_q    <= '0;
        remain_q   <= drv.count;
        ramp_cnt_q <= '0;
        tick_q     <= '0;
        dec_q      <= 1'b0;
      end
    end else begin
      pulse_q <= fire;
      tick_q  <= tick ? '0 : tick_q + 1'b1;
      if (fire) begin
        phase_q <= LHS_PPS_W'(phase_sum - {1'b0, CLK_PPS});
        if (drv.count_en)
          remain_q <= remain_q - 1'b1;
        if (accel_ok)
          ramp_cnt_q <= ramp_cnt_q + 1'b1;
      end else begin
        phase_q <= LHS_PPS_W'(phase_sum);
      end
      if (drv.stop_now || count_end || (drv.stop_slow && !ramp_q)) begin
        busy_q <= 1'b0;
      end else if (drv.stop_slow || (near_end && ramp_q)) begin
        dec_q <= 1'b1;
      end
      if (tick && ramp_q) begin
        if (dec_q) begin
          if (floor_hit && !drv.count_en)
            busy_q <= 1'b0;
          else if (!floor_hit)
            speed_q <= speed_q - drv.accel_pps;
        end else if (accel_ok) begin
          speed_q <= speed_up;
        end
      end
    end
  end
endmodule : lhs_pulse_gen
`default_nettype wire

// ### rtl/lhs_sequencer.sv
// Limit-based home-search sequencer with stored program slots
//
// Functional notes
// - Limit with slow stop mode selected decelerates and stops the fast step; the offset step slows but runs out its count; slow-speed moves stop at once.
// - Limit inputs count as active only while matching the chosen level.
// - High search speed is the speed value times the multiplier.
// - Every trapezoidal move begins at the start speed.
// - Offset step outputs the configured pulse count.
// - Near-home and home inputs each have their own active level.
// - Four steps each have enable and direction; disabled steps skip.
// - Position clear zeroes the position counter after the sequence.
// - Sixty-four program slots are stored per axis.
// - A program may start from any slot.
// - Host, parallel port or remote box may start a program.
// - Step one runs fast to the stop signal then decelerates.
// - Stop signal already active at start skips step one.
// - Step two escapes until clear, then searches slowly and stops.
`timescale 1ns/1ns
`default_nettype none
module lhs_sequencer #(
  parameter int unsigned ACC_TICK_CYC = lhs_pkg::LHS_ACC_TICK_CYC
) (
  input  wire logic                            mclk,
  input  wire logic                            reset,
  input  wire logic                            home_start,
  input  wire logic                            limit_slow_stop,
  input  wire logic                            limit_active_level,
  input  wire logic                            near_home_level,
  input  wire logic                            home_level,
  input  wire logic                            index_level,
  input  wire logic [lhs_pkg::LHS_STEPS-1:0]   step_enable,
  input  wire logic [lhs_pkg::LHS_STEPS-1:0]   step_dir_plus,
  input  wire logic                            position_clear_en,
  input  wire logic                            use_limit,
  input  wire logic                            dcc_enable,
  input  wire logic                            dcc_level,
  input  wire logic [lhs_pkg::LHS_MULT_W-1:0]  speed_mult,
  input  wire logic [lhs_pkg::LHS_SPD_W-1:0]   start_speed,
  input  wire logic [lhs_pkg::LHS_SPD_W-1:0]   low_speed,
  input  wire logic [lhs_pkg::LHS_SPD_W-1:0]   high_speed,
  input  wire logic [lhs_pkg::LHS_SPD_W-1:0]   accel_rate,
  input  wire logic [lhs_pkg::LHS_CNT_W-1:0]   offset_pulses,
  input  wire logic                            travel_limit_minus_input,
  input  wire logic                            travel_limit_plus_input,
  input  wire logic                            near_home_input,
  input  wire logic                            home_input,
  input  wire logic                            index_pulse_input,
  output logic                                 pulse_out,
  output logic                                 dir_plus_out,
  output logic                                 deviation_clear_output,
  output logic                                 home_busy,
  output logic                                 home_done,
  output logic [lhs_pkg::LHS_POS_W-1:0]        position,
  input  wire logic                            slot_wr_en,
  input  wire logic [lhs_pkg::LHS_SLOT_W-1:0]  slot_wr_addr,
  input  wire logic [lhs_pkg::LHS_PROG_W-1:0]  slot_wr_data,
  input  wire logic                            run_host,
  input  wire logic                            run_parallel,
  input  wire logic                            run_remote,
  input  wire logic [lhs_pkg::LHS_SLOT_W-1:0]  run_slot_host,
  input  wire logic [lhs_pkg::LHS_SLOT_W-1:0]  run_slot_parallel,
  input  wire logic [lhs_pkg::LHS_SLOT_W-1:0]  run_slot_remote,
  input  wire logic                            prog_advance,
  input  wire logic                            prog_stop,
  output logic                                 prog_running,
  output logic [lhs_pkg::LHS_SLOT_W-1:0]       prog_slot,
  output logic [lhs_pkg::LHS_PROG_W-1:0]       prog_word
);
  import lhs_pkg::*;

  localparam logic [9:0] DCC_TOP = 10'(LHS_DCC_CYC);

  function automatic logic lim_dir(input logic dp, input logic mi,
                                   input logic pl);
    lim_dir = dp ? pl : mi;
  endfunction : lim_dir

  lhs_drv_if drv ();

  lhs_pulse_gen #(.ACC_TICK_CYC(ACC_TICK_CYC)) u_gen (
    .mclk  (mclk),
    .reset (reset),
    .drv   (drv)
  );

  // ============
  // Input synchronisers
  logic [LHS_IN_N-1:0] meta_q;
  logic [LHS_IN_N-1:0] sync_q;
  wire  [LHS_IN_N-1:0] pins = {index_pulse_input, home_input,
                               near_home_input, travel_limit_plus_input,
                               travel_limit_minus_input};

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  // ============
  // Active-level and stop decode
  wire lim_mi = sync_q[LHS_IN_LMT_MINUS] == limit_active_level;
  wire lim_pl = sync_q[LHS_IN_LMT_PLUS] == limit_active_level;
  wire near_a = sync_q[LHS_IN_NEAR] == near_home_level;
  wire home_a = sync_q[LHS_IN_HOME] == home_level;
  wire idx_a  = sync_q[LHS_IN_INDEX] == index_level;

  lhs_state_t           state_q;
  logic [1:0]           step_q;
  logic                 dir_q;
  logic                 go_q;
  logic                 stop_slow_q;
  logic                 stop_now_q;
  logic                 ramp_q;
  logic                 cnt_en_q;
  logic [LHS_PPS_W-1:0] tgt_q;
  logic                 done_q;
  logic                 dcc_q;
  logic [9:0]           dcc_cnt_q;
  logic [LHS_POS_W-1:0] pos_q;

  wire       srch_dir = step_dir_plus[step_q];
  wire       lim_srch = lim_dir(srch_dir, lim_mi, lim_pl);
  wire       lim_fwd  = lim_dir(dir_q, lim_mi, lim_pl);
  wire       cond     = (step_q == LHS_STEP_FAST)  ? (use_limit ? lim_srch
                                                               : near_a) :
                        (step_q == LHS_STEP_HOME)  ? (use_limit ? lim_srch
                                                               : home_a) :
                        (step_q == LHS_STEP_INDEX) ? idx_a : 1'b0;
  wire       moving   = drv.busy || go_q;
  wire       fast_hit = (step_q == LHS_STEP_FAST) && cond;
  wire       slow_req = fast_hit || (lim_fwd && limit_slow_stop);
  wire       last     = step_q == LHS_STEP_OFFSET;

  wire [LHS_PPS_W-1:0] mult = LHS_PPS_W'(speed_mult);
  wire [LHS_PPS_W-1:0] hi_pps = LHS_PPS_W'(high_speed) * mult;
  wire [LHS_PPS_W-1:0] lo_pps = LHS_PPS_W'(low_speed) * mult;

  assign drv.go         = go_q;
  assign drv.ramp       = ramp_q;
  assign drv.count_en   = cnt_en_q;
  assign drv.stop_slow  = stop_slow_q;
  assign drv.stop_now   = stop_now_q;
  assign drv.target_pps = tgt_q;
  assign drv.start_pps  = LHS_PPS_W'(start_speed) * mult;
  assign drv.accel_pps  = LHS_PPS_W'(accel_rate) * mult;
  assign drv.count      = offset_pulses;

  assign pulse_out              = drv.pulse;
  assign dir_plus_out           = dir_q;
  assign deviation_clear_output = dcc_q ? dcc_level : !dcc_level;
  assign home_busy              = state_q != LHS_IDLE;
  assign home_done              = done_q;
  assign position               = pos_q;

  // ============
  // Home-search sequence
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q     <= LHS_IDLE;
      step_q      <= LHS_STEP_FAST;
      dir_q       <= 1'b0;
      go_q        <= 1'b0;
      stop_slow_q <= 1'b0;
      stop_now_q  <= 1'b0;
      ramp_q      <= 1'b0;
      cnt_en_q    <= 1'b0;
      tgt_q       <= '0;
      done_q      <= 1'b0;
      dcc_q       <= 1'b0;
      dcc_cnt_q   <= '0;
    end else begin
      go_q        <= 1'b0;
      stop_slow_q <= 1'b0;
      stop_now_q  <= 1'b0;
      done_q      <= 1'b0;
      unique case (state_q)
        LHS_IDLE: begin
          step_q <= LHS_STEP_FAST;
          if (home_start)
            state_q <= LHS_PICK;
        end
        LHS_PICK: begin
          dir_q    <= srch_dir;
          cnt_en_q <= last;
          if (!step_enable[step_q] ||
              (step_q == LHS_STEP_FAST && cond)) begin
            step_q  <= step_q + 2'h1;
            state_q <= last ? LHS_CLEAR : LHS_PICK;
          end else if (step_q == LHS_STEP_HOME && cond) begin
            dir_q   <= !srch_dir;
            ramp_q  <= 1'b0;
            tgt_q   <= lo_pps;
            go_q    <= 1'b1;
            state_q <= LHS_ESC;
          end else begin
            ramp_q  <= step_q == LHS_STEP_FAST || last;
            tgt_q   <= (step_q == LHS_STEP_FAST || last) ? hi_pps : lo_pps;
            go_q    <= 1'b1;
            state_q <= LHS_MOVE;
          end
        end
        LHS_MOVE: begin
          if (!moving) begin
            state_q <= LHS_WSTOP;
          end else if (cond || lim_fwd) begin
            stop_slow_q <= slow_req;
            stop_now_q  <= !slow_req;
            state_q     <= LHS_WSTOP;
          end
        end
        LHS_WSTOP: begin
          if (!moving && !stop_slow_q && !stop_now_q) begin
            step_q  <= step_q + 2'h1;
            state_q <= last ? LHS_CLEAR : LHS_PICK;
          end
        end
        LHS_ESC: begin
          if (!cond || lim_fwd || !moving) begin
            stop_now_q <= 1'b1;
            state_q    <= LHS_ESCW;
          end
        end
        LHS_ESCW: begin
          if (!moving && !stop_now_q) begin
            dir_q   <= srch_dir;
            go_q    <= 1'b1;
            state_q <= LHS_MOVE;
          end
        end
        LHS_CLEAR: begin
          dcc_q     <= dcc_enable;
          dcc_cnt_q <= DCC_TOP;
          state_q   <= LHS_FIN;
        end
        LHS_FIN: begin
          dcc_cnt_q <= dcc_cnt_q - 10'h001;
          if (dcc_cnt_q == 10'h001 || !dcc_q) begin
            dcc_q   <= 1'b0;
            done_q  <= 1'b1;
            state_q <= LHS_IDLE;
          end
        end
      endcase
    end
  end

  // ============
  // Position counter
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      pos_q <= '0;
    else if (state_q == LHS_CLEAR && position_clear_en)
      pos_q <= '0;
    else if (drv.pulse)
      pos_q <= dir_q ? pos_q + 1'b1 : pos_q - 1'b1;
  end

  // ============
  // Program slots
  logic [LHS_PROG_W-1:0] slot_mem_q [LHS_SLOTS];
  logic                  run_q;
  logic [LHS_SLOT_W-1:0] pc_q;
  logic [LHS_PROG_W-1:0] word_q;

  wire                  run_any  = run_host || run_parallel || run_remote;
  wire [LHS_SLOT_W-1:0] run_slot = run_host     ? run_slot_host :
                                   run_parallel ? run_slot_parallel :
                                                  run_slot_remote;
  wire [LHS_SLOT_W-1:0] pc_next  = run_any ? run_slot :
                                   (run_q && prog_advance) ? pc_q + 1'b1
                                                           : pc_q;

  always_ff @(posedge mclk) begin
    if (slot_wr_en)
      slot_mem_q[slot_wr_addr] <= slot_wr_data;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      run_q  <= 1'b0;
      pc_q   <= '0;
      word_q <= '0;
    end else begin
      run_q  <= run_any || (run_q && !prog_stop);
      pc_q   <= pc_next;
      word_q <= slot_mem_q[pc_next];
    end
  end

  assign prog_running = run_q;
  assign prog_slot    = pc_q;
  assign prog_word    = word_q;
endmodule : lhs_sequencer
`default_nettype wire

// ### rtl/lhs_sequencer_unused.sv
// Spare design file, holds no logic

// ### sim/lhs_sequencer_asserts.sv
// Port checks for the home-search sequencer
`timescale 1ns/1ns
`default_nettype none
module lhs_sequencer_asserts (
  input wire logic                          mclk,
  input wire logic                          reset,
  input wire logic                          home_start,
  input wire logic [lhs_pkg::LHS_STEPS-1:0] step_enable,
  input wire logic                          dcc_enable,
  input wire logic                          position_clear_en,
  input wire logic                          pulse_out,
  input wire logic                          home_busy,
  input wire logic                          home_done,
  input wire logic [lhs_pkg::LHS_POS_W-1:0] position,
  input wire logic                          run_host,
  input wire logic                          run_parallel,
  input wire logic                          run_remote,
  input wire logic [lhs_pkg::LHS_SLOT_W-1:0] run_slot_host,
  input wire logic [lhs_pkg::LHS_SLOT_W-1:0] run_slot_parallel,
  input wire logic [lhs_pkg::LHS_SLOT_W-1:0] run_slot_remote,
  input wire logic                          prog_advance,
  input wire logic                          prog_stop,
  input wire logic                          prog_running,
  input wire logic [lhs_pkg::LHS_SLOT_W-1:0] prog_slot
);
  import lhs_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // ============
  // Home search
  sequence start_idle;
    home_start && !home_busy && !home_done;
  endsequence
  sequence quiet_walk;
    (home_busy && !pulse_out) [*4];
  endsequence
  busy_rise_a: assert property (start_idle |=> home_busy)
    else $error("no busy after start");
  done_pulse_a: assert property (home_done |=> !home_done)
    else $error("done too long");
  done_busy_a: assert property (home_done |-> $past(home_busy))
    else $error("done while idle");
  busy_fall_a: assert property (
    $fell(home_busy) |-> home_done || $past(home_done))
    else $error("busy fell without done");
  skip_walk_a: assert property (
    start_idle ##0 (step_enable == '0 && !dcc_enable)
      |=> quiet_walk ##[1:4] home_done)
    else $error("steps not skipped");
  clear_zero_a: assert property (
    home_done && position_clear_en |-> position == '0)
    else $error("position not cleared");
  idle_still_a: assert property (
    !home_busy && !$past(home_busy) |-> !pulse_out)
    else $error("pulse while idle");
  // ============
  // Program slots
  run_host_a: assert property (
    run_host |=> prog_running && prog_slot == $past(run_slot_host))
    else $error("host slot");
  run_par_a: assert property (
    !run_host && run_parallel |=> prog_slot == $past(run_slot_parallel))
    else $error("parallel slot");
  run_rem_a: assert property (
    !run_host && !run_parallel && run_remote
      |=> prog_slot == $past(run_slot_remote))
    else $error("remote slot");
  slot_step_a: assert property (
    prog_running && prog_advance && !prog_stop
      && !(run_host || run_parallel || run_remote)
      |=> prog_slot == $past(prog_slot) + 6'h1)
    else $error("advance slot");
endmodule : lhs_sequencer_asserts
bind lhs_sequencer lhs_sequencer_asserts i_chk (
  .mclk, .reset, .home_start, .step_enable, .dcc_enable, .position_clear_en,
  .pulse_out, .home_busy, .home_done, .position, .run_host, .run_parallel,
  .run_remote, .run_slot_host, .run_slot_parallel, .run_slot_remote,
  .prog_advance, .prog_stop, .prog_running, .prog_slot);
`default_nettype wire

// ### sim/lhs_motor_model.sv
// Motor driver and limit sensor model
`timescale 1ns/1ns
`default_nettype none
module lhs_motor_model (
  input  wire logic mclk,
  input  wire logic pulse_out,
  input  wire logic dir_plus_out,
  input  wire logic act_level,
  input  wire logic load,
  input  var  int   load_pos,
  output logic      lmt_minus_pin,
  output logic      lmt_plus_pin,
  output logic      first_dir,
  output var  int   pos,
  output var  int   deep,
  output var  int   flips,
  output var  int   run_len,
  output var  int   npulse,
  output var  int   min_gap,
  output var  int   first_gap
);
  int   gap;
  logic last_dir;
  // ============
  // Minus limit active from position 0 downward, plus never
  assign lmt_minus_pin = (pos <= 0) ? act_level : !act_level;
  assign lmt_plus_pin  = !act_level;
  // ============
  // Axis travel and pulse timing
  always_ff @(posedge mclk) begin
    if (load) begin
      pos       <= load_pos;
      deep      <= load_pos;
      flips     <= 0;
      run_len   <= 0;
      npulse    <= 0;
      min_gap   <= 1000000;
      first_gap <= 0;
      gap       <= 0;
    end else if (pulse_out) begin
      pos      <= dir_plus_out ? pos + 1 : pos - 1;
      deep     <= (!dir_plus_out && pos <= deep) ? pos - 1 : deep;
      gap      <= 1;
      npulse   <= npulse + 1;
      last_dir <= dir_plus_out;
      if (npulse == 0) first_dir <= dir_plus_out;
      if (npulse == 1) first_gap <= gap;
      if (npulse > 0 && dir_plus_out != last_dir) begin
        flips   <= flips + 1;
        run_len <= 1;
      end else begin
        run_len <= run_len + 1;
        if (npulse > 0 && gap < min_gap) min_gap <= gap;
      end
    end else begin
      gap <= gap + 1;
    end
  end
endmodule : lhs_motor_model
`default_nettype wire

// ### sim/lhs_sequencer_tb_top.sv
// Bench for the home-search sequencer
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module lhs_sequencer_tb_top;
  import lhs_pkg::*;
  localparam int OFFSET    = 20;
  localparam int TOP_GAP   = 50_000_000 / (5000 * 100);
  localparam int START_GAP = 50_000_000 / (2000 * 100);
  logic        mclk, reset, home_start, slow_stop, lvl, clr_en, use_lmt;
  logic        dcc_en, dcc_lvl, m_load, wr_en, run_host, run_par, run_rem;
  logic        adv, stop, lmt_m, lmt_p, m_first_dir, pulse, dir_plus;
  logic        home_busy, home_done, prog_running;
  logic [3:0]  step_en, step_dir;
  logic [5:0]  wr_addr, slot_h, slot_p, slot_r, prog_slot;
  logic [7:0]  mult;
  logic [15:0] start_spd, low_spd, high_spd, accel;
  logic [23:0] offset;
  logic [31:0] wr_data, position, prog_word;
  int          failures, n_compared, m_at, m_pos, m_deep, m_flips;
  int          m_run_len, m_npulse, m_min_gap, m_first_gap;
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  lhs_sequencer #(.ACC_TICK_CYC(50)) i_dut (
    .mclk(mclk), .reset(reset), .home_start(home_start),
    .limit_slow_stop(slow_stop), .limit_active_level(lvl),
    .near_home_level(lvl), .home_level(lvl), .index_level(lvl),
    .step_enable(step_en), .step_dir_plus(step_dir),
    .position_clear_en(clr_en), .use_limit(use_lmt),
    .dcc_enable(dcc_en), .dcc_level(dcc_lvl), .speed_mult(mult),
    .start_speed(start_spd), .low_speed(low_spd), .high_speed(high_spd),
    .accel_rate(accel), .offset_pulses(offset),
    .travel_limit_minus_input(lmt_m), .travel_limit_plus_input(lmt_p),
    .near_home_input(lmt_m), .home_input(lmt_m),
    .index_pulse_input(lmt_p), .pulse_out(pulse), .dir_plus_out(dir_plus),
    .deviation_clear_output(), .home_busy(home_busy),
    .home_done(home_done), .position(position), .slot_wr_en(wr_en),
    .slot_wr_addr(wr_addr), .slot_wr_data(wr_data), .run_host(run_host),
    .run_parallel(run_par), .run_remote(run_rem), .run_slot_host(slot_h),
    .run_slot_parallel(slot_p), .run_slot_remote(slot_r),
    .prog_advance(adv), .prog_stop(stop), .prog_running(prog_running),
    .prog_slot(prog_slot), .prog_word(prog_word));
  lhs_motor_model i_motor (
    .mclk(mclk), .pulse_out(pulse), .dir_plus_out(dir_plus),
    .act_level(lvl), .load(m_load), .load_pos(m_at),
    .lmt_minus_pin(lmt_m), .lmt_plus_pin(lmt_p), .first_dir(m_first_dir),
    .pos(m_pos), .deep(m_deep), .flips(m_flips), .run_len(m_run_len),
    .npulse(m_npulse), .min_gap(m_min_gap), .first_gap(m_first_gap));
  // ============
  // Shared tasks
  task automatic home(input int at, output int k);
    k = 0;
    @(posedge mclk);
    m_load <= 1'b1;
    m_at   <= at;
    repeat (4) @(posedge mclk);
    m_load     <= 1'b0;
    home_start <= 1'b1;
    @(posedge mclk);
    home_start <= 1'b0;
    @(negedge mclk);
    while (home_done !== 1'b1 && k < 40000) begin
      @(negedge mclk);
      k++;
    end
    `CHK("home done", 1'b1, home_done)
  endtask : home
  task automatic prog(input logic [4:0] req, input logic [5:0] s, exp);
    @(posedge mclk);
    {run_host, run_par, run_rem, adv, stop} <= req;
    slot_h <= s;
    slot_p <= s ^ 6'h15;
    slot_r <= s ^ 6'h2A;
    @(posedge mclk);
    {run_host, run_par, run_rem, adv, stop} <= 5'h00;
    @(negedge mclk);
    `CHK("prog slot", exp, prog_slot)
    `CHK("prog word", 32'hC0DE0000 + 32'(exp), prog_word)
    `CHK("prog running", !req[0], prog_running)
  endtask : prog
  // ============
  // Scenarios
  task automatic t_limit_home();
    int k;
    @(posedge mclk);
    slow_stop <= 1'b1;
    lvl       <= 1'b0;
    step_en   <= 4'hB;
    step_dir  <= 4'h8;
    clr_en    <= 1'b1;
    home(60, k);
    `CHK("first dir", 1'b0, m_first_dir)
    `CHK("reversals", 3, m_flips)
    `CHK("slow stop depth", 1'b1, m_deep <= -2)
    `CHK("top gap", 1'b1, m_min_gap >= TOP_GAP - 1 && m_min_gap <= TOP_GAP + 1)
    `CHK("start gap", 1'b1, m_first_gap >= START_GAP * 4 / 5 && m_first_gap <= START_GAP + 5)
    `CHK("offset run", OFFSET, m_run_len)
    `CHK("end place", OFFSET, m_pos)
    `CHK("position", 32'h00000000, position)
  endtask : t_limit_home
  task automatic t_inside_limit();
    int k;
    @(posedge mclk);
    slow_stop <= 1'b0;
    lvl       <= 1'b1;
    clr_en    <= 1'b0;
    home(-3, k);
    `CHK("first dir", 1'b1, m_first_dir)
    `CHK("reversals", 2, m_flips)
    `CHK("end place", OFFSET, m_pos)
    `CHK("position", 32'(OFFSET + 3), position)
  endtask : t_inside_limit
  task automatic t_all_skip();
    int k;
    @(posedge mclk);
    step_en <= 4'h0;
    clr_en  <= 1'b1;
    home(5, k);
    `CHK("walk length", 1'b1, k <= 8)
    `CHK("no pulses", 0, m_npulse)
    `CHK("position", 32'h00000000, position)
  endtask : t_all_skip
  task automatic t_program();
    for (int i = 0; i < LHS_SLOTS; i++) begin
      @(posedge mclk);
      wr_en   <= 1'b1;
      wr_addr <= i[5:0];
      wr_data <= 32'hC0DE0000 + 32'(i);
    end
    @(posedge mclk);
    wr_en <= 1'b0;
    prog(5'h10, 6'h3F, 6'h3F);
    prog(5'h02, 6'h00, 6'h00);
    prog(5'h08, 6'h04, 6'h11);
    prog(5'h04, 6'h02, 6'h28);
    prog(5'h14, 6'h05, 6'h05);
    prog(5'h01, 6'h00, 6'h05);
  endtask : t_program
  task automatic summarize();
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  // ============
  // Main sequence and watchdog
  initial begin
    {home_start, slow_stop, lvl, clr_en, dcc_en, dcc_lvl, m_load} = '0;
    {wr_en, run_host, run_par, run_rem, adv, stop} = '0;
    {step_en, step_dir, wr_addr, slot_h, slot_p, slot_r, wr_data} = '0;
    use_lmt    = 1'b1;
    mult       = 8'h64;
    start_spd  = 16'h07D0;
    low_spd    = 16'h03E8;
    high_spd   = 16'h1388;
    accel      = 16'h0050;
    offset     = OFFSET[23:0];
    m_at       = 0;
    failures   = 0;
    n_compared = 0;
    reset      = 1'b1;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    t_limit_home();
    t_inside_limit();
    t_all_skip();
    t_program();
    summarize();
  end
  initial begin
    repeat (90000) @(posedge mclk);
    failures++;
    summarize();
  end
endmodule : lhs_sequencer_tb_top
`default_nettype wire
